// File: rtl/gdfc_pkg.sv
package gdfc_pkg;
  // ****************************************************************
  // Register addresses and codes.
  // ****************************************************************
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_VDSGDF = 4'h1;
  localparam logic [3:0] ADDR_MAIN = 4'h2;
  localparam logic [3:0] ADDR_DRIVE = 4'h3;
  localparam logic [3:0] ADDR_VDS = 4'h4;
  localparam logic [3:0] ADDR_CONFIG = 4'h5;
  localparam logic [2:0] LOCK_ON = 3'h6;
  localparam logic [2:0] LOCK_OFF = 3'h3;
  // ****************************************************************
  // Frame and field positions.
  // ****************************************************************
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_LAST = 5'h04;
  localparam logic [4:0] DATA_FIRST = 5'h08;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 11;
  localparam int MAIN_LOCK_LSB = 3;
  localparam int MAIN_IN1 = 2;
  localparam int MAIN_IN2 = 1;
  localparam int MAIN_CLR = 0;
  localparam int DRV_WDEN = 5;
  localparam int DRV_WDDLY_LSB = 3;
  localparam int ST_SUM = 7;
  localparam int ST_WD = 6;
  localparam int ST_GATE = 5;
  localparam int ST_OVERCUR = 4;
  localparam int ST_VM = 3;
  localparam int ST_VCP = 2;
  localparam int ST_HOT = 1;
  localparam int ST_WARN = 0;
  // ****************************************************************
  // Values after reset.
  // ****************************************************************
  localparam logic [7:0] MAIN_RST = 8'h18;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic [7:0] VDS_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_MHZ = 40;
  localparam int WDPULSE_US = 64;
  localparam logic [23:0] WDPULSE_CYC = 24'(WDPULSE_US * CLK_MHZ);
  localparam logic [1:0] BOOT_LATCH = 2'h2;
  // Power states of the device.
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_SLEEP_WAIT,
    PWR_ASLEEP,
    PWR_WAKING
  } gdfc_pwr_e;
endpackage

// File: rtl/gdfc_sync.sv
`timescale 1ns/1ps
module gdfc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  // Two flip-flops bring each level into the system clock domain.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// File: rtl/gdfc_top.sv
`timescale 1ns/1ps
module gdfc_top
  import gdfc_pkg::*;
#(
  parameter int SLEEP_US = 100,
  parameter int WAKE_US = 1000,
  parameter int RETRY_US = 3000,
  parameter int WD_UNIT_US = 10000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdi,
  input wire logic sleep_in_n,
  input wire logic [1:0] mode_pins,
  input wire logic thermal_shutdown,
  input wire logic overtemp_warning_bit,
  input wire logic overcurrent_trip,
  input wire logic gate_drive_fault,
  input wire logic pump_undervoltage,
  input wire logic supply_undervoltage_lockout,
  input wire logic [7:0] fet_fault_detail,
  output logic sdo,
  output logic sdo_oe,
  output logic frame_error,
  output logic fault_out_n,
  output logic watchdog_fault_out_n,
  output logic bridge_enable,
  output logic charge_pump_enable,
  output logic analog_regulator_enable,
  output logic digital_regulator_enable,
  output logic sleep_active,
  output logic [1:0] ctrl_mode,
  output logic [7:0] main_ctrl_ff,
  output logic [7:0] drive_ctrl_ff,
  output logic [7:0] vds_ctrl_ff,
  output logic [7:0] config_ctrl_ff
);
  // ****************************************************************
  // Derived counts and parameter checks.
  // ****************************************************************
  localparam logic [23:0] SLEEP_CYC = 24'(SLEEP_US * CLK_MHZ);
  localparam logic [23:0] WAKE_CYC = 24'(WAKE_US * CLK_MHZ);
  localparam logic [23:0] RETRY_CYC = 24'(RETRY_US * CLK_MHZ);
  localparam logic [23:0] WD_UNIT_CYC = 24'(WD_UNIT_US * CLK_MHZ);

  generate
    if (SLEEP_US < 1 || WAKE_US < 1 || RETRY_US < 1 || WD_UNIT_US < 1) begin : g_chk_min
      $error("gdfc_top: every time must be at least 1 us");
    end
    if (longint'(WD_UNIT_US) * CLK_MHZ * 4 >= 64'h1000000 ||
        longint'(WAKE_US) * CLK_MHZ >= 64'h1000000 ||
        longint'(SLEEP_US) * CLK_MHZ >= 64'h1000000 ||
        longint'(RETRY_US) * CLK_MHZ >= 64'h1000000) begin : g_chk_max
      $error("gdfc_top: a time does not fit the 24-bit counters");
    end
  endgenerate

  // ****************************************************************
  // Input synchronisation.
  // ****************************************************************
  logic [19:0] pinsQ;
  logic sclkQ, selQ, csnQ, sdiQ, sleepQ, hotQ, warnQ, overCurQ, gateFltQ, pumpLowQ, vmuvQ;
  logic [1:0] modeQ;
  logic [7:0] fetQ;

  // Select enters inverted, so the reset value of the synchroniser reads as deselected.
  gdfc_sync #(.W(20)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({sclk, ~serial_select_n, sdi, sleep_in_n, mode_pins, thermal_shutdown,
        overtemp_warning_bit, overcurrent_trip, gate_drive_fault,
        pump_undervoltage, supply_undervoltage_lockout, fet_fault_detail}),
    .q(pinsQ)
  );

  // Unpack the synchronised pins.
  assign {sclkQ, selQ, sdiQ, sleepQ, modeQ, hotQ, warnQ, overCurQ, gateFltQ,
          pumpLowQ, vmuvQ, fetQ} = pinsQ;
  assign csnQ = ~selQ; // No false select edge after reset.

  // ****************************************************************
  // Serial link.
  // ****************************************************************
  logic sclkPrev_ff, csnPrev_ff, rwBit_ff;
  logic [4:0] bitCnt_ff;
  logic [15:0] rxShift_ff;
  logic [7:0] txByte_ff;
  logic sclkFall, sclkRise, frameStart, frameEnd, fullFrame;
  logic [3:0] rxAddr;
  logic [7:0] rxData;
  logic wrOk, wdKick;
  logic [7:0] statusReg, fetFlags_ff;
  logic [6:1] flags_ff;

  // Returns the present contents of one register.
  function automatic logic [7:0] reg_read(input logic [3:0] addr);
    begin
      unique case (addr)
        ADDR_STATUS: reg_read = statusReg;
        ADDR_VDSGDF: reg_read = fetFlags_ff;
        ADDR_MAIN: reg_read = main_ctrl_ff;
        ADDR_DRIVE: reg_read = drive_ctrl_ff;
        ADDR_VDS: reg_read = vds_ctrl_ff;
        ADDR_CONFIG: reg_read = config_ctrl_ff;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // Edges only count while select is low.
  assign sclkFall = sclkPrev_ff & ~sclkQ & ~csnQ;
  assign sclkRise = ~sclkPrev_ff & sclkQ & ~csnQ;
  assign frameStart = csnPrev_ff & ~csnQ;
  assign frameEnd = ~csnPrev_ff & csnQ;
  assign fullFrame = (bitCnt_ff == FRAME_BITS);
  assign rxAddr = rxShift_ff[ADDR_MSB:ADDR_LSB];
  assign rxData = rxShift_ff[7:0];
  assign wrOk = frameEnd & fullFrame & ~rwBit_ff;
  assign wdKick = frameEnd & fullFrame & rwBit_ff & (rxAddr == ADDR_STATUS);

  // Edge history of clock and select.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclkPrev_ff <= 1'b0;
      csnPrev_ff <= 1'b1;
    end else begin
      sclkPrev_ff <= sclkQ;
      csnPrev_ff <= csnQ;
    end
  end

  // Receive shifter, MSB first, sampled on the falling clock edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bitCnt_ff <= 5'h00;
      rxShift_ff <= 16'h0000;
      rwBit_ff <= 1'b0;
    end else if (frameStart) begin
      bitCnt_ff <= 5'h00;
      rxShift_ff <= 16'h0000;
      rwBit_ff <= 1'b0;
    end else if (sclkFall) begin
      rxShift_ff <= {rxShift_ff[14:0], sdiQ};
      if (bitCnt_ff != 5'h1f) begin
        bitCnt_ff <= bitCnt_ff + 5'h01; // Saturates so long frames stay wrong.
      end
      if (bitCnt_ff == 5'h00) begin
        rwBit_ff <= sdiQ;
      end
    end
  end

  // Reply byte is captured after the command, before any write lands.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txByte_ff <= 8'h00;
    end else if (sclkFall && bitCnt_ff == CMD_LAST) begin
      txByte_ff <= reg_read({rxShift_ff[2:0], sdiQ});
    end else if (sclkRise && bitCnt_ff >= DATA_FIRST) begin
      txByte_ff <= {txByte_ff[6:0], 1'b0};
    end
  end

  // Output pin launched on the rising edge; floats while deselected.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= ~csnQ;
      if (csnQ || frameStart) begin
        sdo <= 1'b0;
      end else if (sclkRise) begin
        sdo <= (bitCnt_ff >= DATA_FIRST) ? txByte_ff[7] : 1'b0;
      end
    end
  end

  // A write of the wrong length is dropped and reported for one cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_error <= 1'b0;
    end else begin
      frame_error <= frameEnd & ~fullFrame & ~rwBit_ff;
    end
  end

  // ****************************************************************
  // Power states and mode latch.
  // ****************************************************************
  gdfc_pwr_e pwrState_ff;
  logic [23:0] pwrCnt_ff;
  logic [1:0] bootCnt_ff;
  logic settingsReset, wakeDone;

  assign settingsReset = (pwrState_ff == PWR_ASLEEP) & sleepQ;
  assign wakeDone = (pwrState_ff == PWR_WAKING) & (pwrCnt_ff == 24'h1);

  // Sleep entry after the delay; wake after the wake time.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwrState_ff <= PWR_ACTIVE;
      pwrCnt_ff <= 24'h0;
    end else begin
      unique case (pwrState_ff)
        PWR_ACTIVE: begin
          if (!sleepQ) begin
            pwrState_ff <= PWR_SLEEP_WAIT;
            pwrCnt_ff <= SLEEP_CYC;
          end
        end
        PWR_SLEEP_WAIT: begin
          if (sleepQ) begin
            pwrState_ff <= PWR_ACTIVE;
          end else if (pwrCnt_ff == 24'h1) begin
            pwrState_ff <= PWR_ASLEEP;
          end else begin
            pwrCnt_ff <= pwrCnt_ff - 24'h1;
          end
        end
        PWR_ASLEEP: begin
          if (sleepQ) begin
            pwrState_ff <= PWR_WAKING;
            pwrCnt_ff <= WAKE_CYC;
          end
        end
        PWR_WAKING: begin
          if (!sleepQ) begin
            pwrState_ff <= PWR_SLEEP_WAIT;
            pwrCnt_ff <= SLEEP_CYC;
          end else if (wakeDone) begin
            pwrState_ff <= PWR_ACTIVE;
          end else begin
            pwrCnt_ff <= pwrCnt_ff - 24'h1;
          end
        end
      endcase
    end
  end

  // Mode is caught once the synchroniser has settled, and on each wake.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bootCnt_ff <= 2'h0;
      ctrl_mode <= 2'h0;
    end else begin
      if (bootCnt_ff != 2'h3) begin
        bootCnt_ff <= bootCnt_ff + 2'h1;
      end
      if (bootCnt_ff == BOOT_LATCH || wakeDone) begin
        ctrl_mode <= modeQ;
      end
    end
  end

  // ****************************************************************
  // Settings registers.
  // ****************************************************************
  logic locked, clrFault, wdExpire;

  assign locked = (main_ctrl_ff[5:3] == LOCK_ON);
  assign clrFault = wrOk & (rxAddr == ADDR_MAIN) & rxData[MAIN_CLR];

  // Main control accepts writes even while locked.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_ctrl_ff <= MAIN_RST;
    end else if (settingsReset) begin
      main_ctrl_ff <= MAIN_RST;
    end else if (wrOk && rxAddr == ADDR_MAIN) begin
      main_ctrl_ff[7:6] <= rxData[7:6];
      main_ctrl_ff[MAIN_IN1] <= rxData[MAIN_IN1];
      main_ctrl_ff[MAIN_IN2] <= rxData[MAIN_IN2];
      main_ctrl_ff[MAIN_CLR] <= 1'b0; // Clear-fault acts once and reads zero.
      if (!locked && rxData[5:3] == LOCK_ON) begin
        main_ctrl_ff[5:3] <= LOCK_ON;
      end else if (locked && rxData[5:3] == LOCK_OFF) begin
        main_ctrl_ff[5:3] <= LOCK_OFF;
      end
    end
  end

  // Drive and watchdog control; expiry clears the enable over a write.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_ctrl_ff <= DRIVE_RST;
    end else if (settingsReset) begin
      drive_ctrl_ff <= DRIVE_RST;
    end else begin
      if (wrOk && rxAddr == ADDR_DRIVE && !locked) begin
        drive_ctrl_ff <= rxData;
      end
      if (wdExpire) begin
        drive_ctrl_ff[DRV_WDEN] <= 1'b0;
      end
    end
  end

  // Remaining settings; held while locked.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vds_ctrl_ff <= VDS_RST;
      config_ctrl_ff <= CONFIG_RST;
    end else if (settingsReset) begin
      vds_ctrl_ff <= VDS_RST;
      config_ctrl_ff <= CONFIG_RST;
    end else if (wrOk && !locked) begin
      if (rxAddr == ADDR_VDS) begin
        vds_ctrl_ff <= rxData;
      end
      if (rxAddr == ADDR_CONFIG) begin
        config_ctrl_ff <= rxData;
      end
    end
  end

  // ****************************************************************
  // Watchdog.
  // ****************************************************************
  logic [23:0] wdCnt_ff, wdLoad, wdPulse_ff;
  logic wdEn;

  assign wdEn = drive_ctrl_ff[DRV_WDEN];
  assign wdLoad = WD_UNIT_CYC * {22'h0, drive_ctrl_ff[DRV_WDDLY_LSB+:2]} + WD_UNIT_CYC;
  assign wdExpire = wdEn & ~wdKick & (wdCnt_ff == 24'h1);

  // Interval count, idle while disabled; the first enabled cycle loads the interval now set.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdCnt_ff <= 24'h0;
    end else if (!wdEn) begin
      wdCnt_ff <= 24'h0;
    end else if (wdKick || wdCnt_ff == 24'h0) begin
      wdCnt_ff <= wdLoad;
    end else begin
      wdCnt_ff <= wdCnt_ff - 24'h1;
    end
  end

  // Watchdog fault pin low for a fixed pulse after expiry.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdPulse_ff <= 24'h0;
      watchdog_fault_out_n <= 1'b1;
    end else begin
      if (wdExpire) begin
        wdPulse_ff <= WDPULSE_CYC;
      end else if (wdPulse_ff != 24'h0) begin
        wdPulse_ff <= wdPulse_ff - 24'h1;
      end
      watchdog_fault_out_n <= (wdPulse_ff == 24'h0);
    end
  end

  // ****************************************************************
  // Fault flags and responses.
  // ****************************************************************
  logic [23:0] retryCnt_ff;
  logic [6:1] flagSet;
  logic retryActive, awake, thermalOff;

  assign flagSet = {wdExpire, gateFltQ, overCurQ, vmuvQ, pumpLowQ, hotQ};
  assign statusReg = {|flags_ff, flags_ff, warnQ};
  assign retryActive = (retryCnt_ff != 24'h0);
  assign awake = (pwrState_ff == PWR_ACTIVE);
  assign thermalOff = hotQ | vmuvQ;

  // Sticky flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_ff <= 6'h00;
      fetFlags_ff <= 8'h00;
    end else begin
      flags_ff <= flagSet | (flags_ff & ~{6{clrFault}});
      fetFlags_ff <= fetQ | (fetFlags_ff & ~{8{clrFault}});
    end
  end

  // Overcurrent and gate faults stop the bridge for one retry time.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      retryCnt_ff <= 24'h0;
    end else if (!retryActive && (overCurQ || gateFltQ) && awake) begin
      retryCnt_ff <= RETRY_CYC;
    end else if (retryActive) begin
      retryCnt_ff <= retryCnt_ff - 24'h1;
    end
  end

  // Enables and fault pin; bridge held off while waking or asleep.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bridge_enable <= 1'b0;
      charge_pump_enable <= 1'b0;
      analog_regulator_enable <= 1'b0;
      digital_regulator_enable <= 1'b0;
      fault_out_n <= 1'b1;
      sleep_active <= 1'b0;
    end else begin
      bridge_enable <= awake & ~thermalOff & ~pumpLowQ & ~retryActive &
                       ~flags_ff[ST_WD] & ~wdExpire;
      charge_pump_enable <= (pwrState_ff != PWR_ASLEEP) & ~thermalOff;
      analog_regulator_enable <= (pwrState_ff != PWR_ASLEEP) & ~thermalOff;
      digital_regulator_enable <= (pwrState_ff != PWR_ASLEEP);
      fault_out_n <= ~(thermalOff | pumpLowQ | retryActive | flags_ff[ST_WD] |
                       wdExpire);
      sleep_active <= (pwrState_ff == PWR_ASLEEP);
    end
  end
endmodule

// File: verif/gdfc_spi_master.sv
`timescale 1ns/1ps
module gdfc_spi_master (
  input wire logic clk_sys,
  input wire logic sdo,
  output logic sclk,
  output logic serial_select_n,
  output logic sdi
);
  // Link idles with the clock low and the device deselected.
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    sdi = 1'b1;
  end
  // ****
  // Frame of n clocks, MSB first, launched on rise, reply taken on fall.
  // ****
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] r);
    r = 8'h00;
    @(negedge clk_sys) serial_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge clk_sys);
      sdi = (i < 16) ? w[15-i] : 1'b0;
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      sclk = 1'b0;
      r = {r[6:0], sdo};
    end
    repeat (4) @(negedge clk_sys);
    serial_select_n = 1'b1;
    sdi = ~sdi; // A released line never keeps its last value.
    repeat (24) @(negedge clk_sys);
  endtask
endmodule

// File: verif/gdfc_properties.sv
`timescale 1ns/1ps
module gdfc_properties
  import gdfc_pkg::*;
#(
  parameter int SLEEP_US = 100
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serial_select_n,
  input wire logic sleep_in_n,
  input wire logic thermal_shutdown,
  input wire logic sdo_oe,
  input wire logic frame_error,
  input wire logic fault_out_n,
  input wire logic watchdog_fault_out_n,
  input wire logic bridge_enable,
  input wire logic charge_pump_enable,
  input wire logic analog_regulator_enable,
  input wire logic digital_regulator_enable,
  input wire logic sleep_active,
  input wire logic [7:0] main_ctrl_ff,
  input wire logic [7:0] drive_ctrl_ff,
  input wire logic [7:0] vds_ctrl_ff,
  input wire logic [7:0] config_ctrl_ff
);
  localparam int SLEEP_CYC = SLEEP_US * CLK_MHZ;
  int wdLow;
  int sleepLow;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Counters of the watchdog pulse length and of the sleep request length.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdLow <= 0;
      sleepLow <= 0;
    end else begin
      wdLow <= watchdog_fault_out_n ? 0 : wdLow + 1;
      sleepLow <= sleep_in_n ? 0 : sleepLow + 1;
    end
  end
  sequence s_hot_held;
    thermal_shutdown [*6];
  endsequence
  sequence s_wd_expiry;
    $fell(watchdog_fault_out_n);
  endsequence
  a_hot_off: assert property (s_hot_held |-> sleep_active || (!bridge_enable &&
    !charge_pump_enable && !analog_regulator_enable && !fault_out_n))
    else $error("overtemp left outputs on");
  a_wd_pulse_len: assert property ($rose(watchdog_fault_out_n) |-> wdLow == WDPULSE_CYC)
    else $error("watchdog pulse length wrong");
  a_wd_expiry_acts: assert property (s_wd_expiry |-> ##[0:3] (!fault_out_n &&
    !bridge_enable && !drive_ctrl_ff[DRV_WDEN]))
    else $error("watchdog expiry actions missing");
  a_sdo_float: assert property (serial_select_n [*5] |-> !sdo_oe)
    else $error("serial output driven while deselected");
  a_frame_err_keep: assert property (frame_error |->
    $stable({main_ctrl_ff, drive_ctrl_ff, vds_ctrl_ff, config_ctrl_ff}) ##1
    $stable({main_ctrl_ff, drive_ctrl_ff, vds_ctrl_ff, config_ctrl_ff}))
    else $error("bad frame changed a register");
  a_sleep_off: assert property (sleep_active |-> !bridge_enable && !charge_pump_enable &&
    !analog_regulator_enable && !digital_regulator_enable)
    else $error("supply left on in sleep");
  a_sleep_delay: assert property ($rose(sleep_active) |-> sleepLow >= SLEEP_CYC)
    else $error("sleep entered early");
  a_wake_hold: assert property ($fell(sleep_active) |-> !bridge_enable [*8])
    else $error("bridge on during wake time");
  a_wake_defaults: assert property ($fell(sleep_active) |-> ##[0:2]
    (main_ctrl_ff == MAIN_RST && drive_ctrl_ff == DRIVE_RST))
    else $error("settings kept across wake");
endmodule
bind gdfc_top gdfc_properties #(.SLEEP_US(SLEEP_US)) u_props (.clk_sys(clk_sys), .rst(rst),
  .serial_select_n(serial_select_n), .sleep_in_n(sleep_in_n),
  .thermal_shutdown(thermal_shutdown), .sdo_oe(sdo_oe), .frame_error(frame_error),
  .fault_out_n(fault_out_n), .watchdog_fault_out_n(watchdog_fault_out_n),
  .bridge_enable(bridge_enable), .charge_pump_enable(charge_pump_enable),
  .analog_regulator_enable(analog_regulator_enable),
  .digital_regulator_enable(digital_regulator_enable), .sleep_active(sleep_active),
  .main_ctrl_ff(main_ctrl_ff), .drive_ctrl_ff(drive_ctrl_ff), .vds_ctrl_ff(vds_ctrl_ff),
  .config_ctrl_ff(config_ctrl_ff));

// File: verif/test_gate_driver_spi_fault_ctrl.sv
`timescale 1ns/1ps
module test_gate_driver_spi_fault_ctrl;
  import gdfc_pkg::*;
  logic clkSys, rst, sclk, selN, sdi, sleepInN, hot, warn, gateFlt, sdo, sdoOe, frameError;
  logic overCur, pumpLow, supplyLow;
  logic faultN, wdFaultN, bridgeEn, pumpEn, avEn, dvEn, sleepAct, wdSeen;
  logic [1:0] modePins, ctrlMode;
  logic [7:0] mainR, driveR, vdsR, cfgR, feCnt, r, fetDet;
  int failCount = 0;
  int nChecks = 0;
  int cycles = 0;
  gdfc_top #(.SLEEP_US(1), .WAKE_US(2), .RETRY_US(2), .WD_UNIT_US(5)) u_dut (
    .clk_sys(clkSys), .rst(rst), .sclk(sclk), .serial_select_n(selN), .sdi(sdi),
    .sleep_in_n(sleepInN), .mode_pins(modePins), .thermal_shutdown(hot),
    .overtemp_warning_bit(warn), .overcurrent_trip(overCur), .gate_drive_fault(gateFlt),
    .pump_undervoltage(pumpLow), .supply_undervoltage_lockout(supplyLow),
    .fet_fault_detail(fetDet),
    .sdo(sdo), .sdo_oe(sdoOe), .frame_error(frameError), .fault_out_n(faultN),
    .watchdog_fault_out_n(wdFaultN), .bridge_enable(bridgeEn), .charge_pump_enable(pumpEn),
    .analog_regulator_enable(avEn), .digital_regulator_enable(dvEn),
    .sleep_active(sleepAct), .ctrl_mode(ctrlMode), .main_ctrl_ff(mainR),
    .drive_ctrl_ff(driveR), .vds_ctrl_ff(vdsR), .config_ctrl_ff(cfgR));
  gdfc_spi_master u_mst (.clk_sys(clkSys), .sdo(sdo), .sclk(sclk), .serial_select_n(selN),
    .sdi(sdi));
  // System clock at 40 MHz.
  initial begin
    clkSys = 1'b0;
    forever #12.5 clkSys = ~clkSys;
  end
  // Monitors of short pulses and the run-time ceiling.
  always @(posedge clkSys) begin
    cycles++;
    if (frameError === 1'b1) feCnt++;
    if (wdFaultN === 1'b0) wdSeen = 1'b1;
    if (cycles == 20000) begin
      failCount++;
      stopTest();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clkSys);
  endtask
  task automatic xf(input logic rw, input logic [3:0] a, input logic [7:0] d);
    u_mst.xfer({rw, a, 3'h0, d}, 16, r);
  endtask
  // Clear-fault write, after which the status reads empty.
  task automatic clr();
    xf(1'b0, ADDR_MAIN, 8'h19);
    xf(1'b1, ADDR_STATUS, 8'h00);
    chk(r, 8'h00, "status after clear");
  endtask
  task automatic testRegs();
    xf(1'b1, ADDR_VDS, 8'h00);
    chk(mainR, MAIN_RST, "main default");
    chk(driveR, DRIVE_RST, "drive default");
    chk({6'h0, ctrlMode}, 8'h01, "mode at power-up");
    xf(1'b0, ADDR_DRIVE, 8'h07);
    chk(r, DRIVE_RST, "reply on write");
    xf(1'b1, ADDR_DRIVE, 8'h00);
    chk(r, 8'h07, "reply on read");
    xf(1'b1, 4'h9, 8'h00);
    chk(r, 8'h00, "unmapped read");
    $display("test regs done");
  endtask
  task automatic testLock();
    xf(1'b0, ADDR_MAIN, 8'h30);
    xf(1'b0, ADDR_VDS, 8'h55);
    chk(vdsR, VDS_RST, "locked write");
    xf(1'b0, ADDR_MAIN, 8'h18);
    chk(r, 8'h30, "main writable locked");
    xf(1'b0, ADDR_VDS, 8'h55);
    chk(vdsR, 8'h55, "unlocked write");
    u_mst.xfer({1'b0, ADDR_CONFIG, 3'h0, 8'haa}, 15, r);
    u_mst.xfer({1'b0, ADDR_CONFIG, 3'h0, 8'haa}, 17, r);
    chk(feCnt, 8'h02, "frame errors");
    chk(cfgR, CONFIG_RST, "bad frames dropped");
    $display("test lock and frames done");
  endtask
  task automatic testFaults();
    warn = 1'b1;
    cyc(8);
    xf(1'b1, ADDR_STATUS, 8'h00);
    chk(r, 8'h01, "warning alone");
    warn = 1'b0;
    hot = 1'b1;
    cyc(10);
    chk({4'h0, bridgeEn, pumpEn, avEn, faultN}, 8'h00, "overtemp off");
    hot = 1'b0;
    cyc(10);
    chk({4'h0, bridgeEn, pumpEn, avEn, faultN}, 8'h0f, "overtemp resumed");
    xf(1'b1, ADDR_STATUS, 8'h00);
    chk(r, 8'h82, "overtemp sticky");
    clr();
    gateFlt = 1'b1;
    cyc(5);
    gateFlt = 1'b0;
    cyc(5);
    chk({5'h0, bridgeEn, pumpEn, avEn}, 8'h03, "gate fault bridge only");
    cyc(100);
    chk({7'h0, bridgeEn}, 8'h01, "gate fault retry");
    // Overcurrent stops the bridge only; supply faults and detail bits stay flagged.
    overCur = 1'b1;
    fetDet = 8'h21;
    cyc(6);
    chk({5'h0, bridgeEn, pumpEn, avEn}, 8'h03, "overcurrent bridge only");
    overCur = 1'b0;
    pumpLow = 1'b1;
    supplyLow = 1'b1;
    cyc(6);
    chk({7'h0, faultN}, 8'h00, "supply low fault pin");
    pumpLow = 1'b0;
    supplyLow = 1'b0;
    fetDet = 8'h00;
    xf(1'b1, ADDR_STATUS, 8'h00);
    chk(r, 8'hbc, "all flags sticky");
    xf(1'b1, ADDR_VDSGDF, 8'h00);
    chk(r, 8'h21, "detail flags sticky");
    clr();
    $display("test faults done");
  endtask
  task automatic testWatchdog();
    xf(1'b0, ADDR_DRIVE, 8'h28);
    repeat (4) xf(1'b1, ADDR_STATUS, 8'h00);
    chk({7'h0, wdSeen}, 8'h00, "kicked in time");
    cyc(500);
    chk({4'h0, wdSeen, driveR[DRV_WDEN], bridgeEn, faultN}, 8'h08, "expiry");
    cyc(2700);
    xf(1'b1, ADDR_STATUS, 8'h00);
    chk(r, 8'hc0, "watchdog flag");
    chk({7'h0, bridgeEn}, 8'h00, "halted");
    clr();
    cyc(8);
    chk({6'h0, bridgeEn, faultN}, 8'h03, "resumed after clear");
    $display("test watchdog done");
  endtask
  task automatic testSleep();
    xf(1'b0, ADDR_DRIVE, 8'h07);
    modePins = 2'h2;
    cyc(8);
    chk({6'h0, ctrlMode}, 8'h01, "mode held");
    sleepInN = 1'b0;
    cyc(20);
    chk({7'h0, sleepAct}, 8'h00, "sleep delay");
    cyc(40);
    chk({3'h0, sleepAct, bridgeEn, pumpEn, avEn, dvEn}, 8'h10, "asleep");
    sleepInN = 1'b1;
    cyc(20);
    chk({7'h0, bridgeEn}, 8'h00, "wake time");
    chk(driveR, DRIVE_RST, "settings reset");
    cyc(100);
    chk({7'h0, bridgeEn}, 8'h01, "awake");
    chk({6'h0, ctrlMode}, 8'h02, "mode relatched");
    $display("test sleep done");
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    rst = 1'b1;
    sleepInN = 1'b1;
    modePins = 2'h1;
    hot = 1'b0;
    warn = 1'b0;
    gateFlt = 1'b0;
    overCur = 1'b0;
    pumpLow = 1'b0;
    supplyLow = 1'b0;
    fetDet = 8'h00;
    feCnt = 8'h00;
    wdSeen = 1'b0;
    cyc(10);
    rst = 1'b0;
    cyc(4);
    testRegs();
    testLock();
    testFaults();
    testWatchdog();
    testSleep();
    stopTest();
  end
endmodule
